/* File: rtl/wdt_tb_pkg.sv */
// Package for the watchdog, timing chain, time base, clock interval and halt block.
// Assumes a single 100 MHz system clock and synchronous active high reset.
package wdt_tb_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] RTC_CONTROL_ADDR = 8'h09;
    localparam logic [7:0] SECOND_IRQ_CONTROL_ADDR = 8'h1E;
    localparam logic [7:0] WDT_STATUS_ADDR = 8'h40;
    localparam logic [7:0] RTC_CONTROL_RESET = 8'h07;
    localparam int RTC_SEL_LSB = 0;
    localparam int QUICK_START_BIT = 4;
    localparam int TB_ENABLE_BIT = 1;
    localparam int CI_ENABLE_BIT = 2;
    localparam int TB_FLAG_BIT = 5;
    localparam int CI_FLAG_BIT = 6;
    localparam int TO_BIT = 0;
    localparam int PD_BIT = 1;
    localparam int HALT_BIT = 2;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int DIVIDER_STAGES = 8;
    localparam int PRESCALER_BITS = 7;
    localparam int CHAIN_BITS = DIVIDER_STAGES + PRESCALER_BITS + 1;
    localparam int INSTR_CLOCK_DIV = 4;
    localparam int WAKE_DELAY_CYCLES = 1024;
    localparam int WDT_MIN_LOG2 = 12;
    localparam int TB_MIN_LOG2 = 12;
    localparam int RTC_MIN_LOG2 = 8;
    localparam int TAP_MIN_LOG2 = 2;
    // ----------------------------------------
    // Source choice and states
    // ----------------------------------------
    localparam logic [1:0] SRC_RC = 2'h0;
    localparam logic [1:0] SRC_INSTR = 2'h1;
    localparam logic [1:0] SRC_RTC = 2'h2;
    typedef enum logic [1:0] {RUN, HALTED, WAKE_DELAY} pwr_state_t;
endpackage : wdt_tb_pkg

/* File: rtl/wdt_timebase.sv */
// Watchdog, shared timing chain, time base, clock interval timer and halt control.
// Assumes oscillator pins come straight from pads and CPU strobes are on clk_sys_in.
//
// Functional notes
// - Watchdog clocked by option-selected source.
// - Disabled watchdog ignores every related action.
// - RC-source time-out after 2^12 to 2^15.
// - Instruction-clock source stops counting while halted.
// - Overflow when running gives chip reset, sets flag.
// - Overflow while halted gives warm reset only.
// - Reset pin, clear instructions, halt clear count.
// - Single or dual clear mode by option.
// - Chain is 8-stage divider plus 7-bit prescaler.
// - LCD tap 2^2..2^8, buzzer tap 2^2..2^9.
// - Time base period 2^12 to 2^15.
// - Time base sets bit 5, vector 14H.
// - Interval select bits 2..0 give 2^8..2^15.
// - Interval time-out sets bit 6, vector 18H.
// - Halt stops system clock, keeps selected oscillators.
// - Halt clears watchdog, restarts on slow sources.
// - Halt sets power-down flag, clears time-out flag.
// - Leave halt on reset, interrupt, port, overflow.
// - Each port A pin enabled for wake-up by its own option bit.
// - Port or masked interrupt wake resumes next instruction.
// - Flag set before halt cannot wake.
// - Wake-up inserts 1024 system clock delay.
// - Quick-start bit 4 of interval control.
`timescale 1ns/1ps
`default_nettype none
module wdt_timebase #(
    parameter int WDT_DIV_SEL = 0,         // Watchdog divide 2^(12+n), n 0..3.
    parameter int TB_DIV_SEL = 0,          // Time base 2^(12+n), n 0..3.
    parameter int LCD_TAP_SEL = 0,         // LCD tap 2^(2+n), n 0..6.
    parameter int BUZ_TAP_SEL = 0          // Buzzer tap 2^(2+n), n 0..7.
) (
    input wire logic clk_sys_in,           // System clock, 100 MHz.
    input wire logic sys_rst_in,           // Synchronous reset, active high.
    input wire logic wdt_enable_in,        // Option: watchdog enabled.
    input wire logic [1:0] wdt_source_in,  // Option: chain clock source.
    input wire logic clear_mode_dual_in,   // Option: dual clear mode.
    input wire logic [7:0] porta_wake_en_in, // Option: port A wake enables.
    input wire logic rc_osc_in,            // Watchdog RC oscillator pin.
    input wire logic rtc_osc_in,           // Crystal oscillator pin.
    input wire logic external_reset_pin_n_in, // External reset pin, active low.
    input wire logic [7:0] porta_in,       // Port A pins.
    input wire logic watchdog_clear_single_in, // Single clear instruction strobe.
    input wire logic watchdog_clear_first_in,  // First clear instruction strobe.
    input wire logic watchdog_clear_second_in, // Second clear instruction strobe.
    input wire logic halt_in,              // Halt instruction strobe.
    input wire logic other_irq_in,         // Other new interrupt request pulse.
    input wire logic stack_full_in,        // Stack is full.
    input wire logic irq_ack_tb_in,        // Time base request serviced.
    input wire logic irq_ack_ci_in,        // Interval request serviced.
    input wire logic [7:0] reg_addr_in,    // Register address.
    input wire logic [7:0] reg_wdata_in,   // Register write data.
    input wire logic reg_wr_in,            // Register write strobe.
    input wire logic reg_rd_in,            // Register read strobe.
    output logic [7:0] reg_rdata_out,      // Register read data.
    output logic chip_reset_out,           // Full chip reset pulse.
    output logic warm_reset_out,           // Program counter and stack reset pulse.
    output logic sysclk_enable_out,        // System oscillator running.
    output logic cpu_run_out,              // Instruction execution allowed.
    output logic irq_call_out,             // Interrupt call pulse.
    output logic [7:0] irq_vector_out,     // Vector of the call.
    output logic lcd_clk_out,              // LCD clock tap.
    output logic buzzer_out,               // Buzzer tap.
    output logic crystal_quick_start_out   // Crystal quick start control.
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] rc_sync, rtc_sync, rst_pin_sync;
    logic [7:0] pa_s1, pa_s2, pa_prev;
    logic rc_prev, rtc_prev;
    always_ff @(posedge clk_sys_in) begin
        rc_sync <= {rc_sync[0], rc_osc_in};
        rtc_sync <= {rtc_sync[0], rtc_osc_in};
        rst_pin_sync <= {rst_pin_sync[0], external_reset_pin_n_in};
        pa_s1 <= porta_in;
        pa_s2 <= pa_s1;
        pa_prev <= pa_s2;
        rc_prev <= rc_sync[1];
        rtc_prev <= rtc_sync[1];
    end
    wire logic pin_reset = ~rst_pin_sync[1];

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    wdt_tb_pkg::pwr_state_t state;
    logic [10:0] wake_cnt;
    logic [1:0] instr_div;
    logic wake_irq_call;
    wire logic halted = (state == wdt_tb_pkg::HALTED);

    // Source tick: one-cycle enable on a rising edge of the chosen source.
    logic src_tick;
    always_comb begin
        case (wdt_source_in)
            wdt_tb_pkg::SRC_RC: src_tick = rc_sync[1] & ~rc_prev;
            wdt_tb_pkg::SRC_RTC: src_tick = rtc_sync[1] & ~rtc_prev;
            // Instruction clock is stopped while halted.
            default: src_tick = (state == wdt_tb_pkg::RUN) && (instr_div == 2'h3);
        endcase
    end
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || state != wdt_tb_pkg::RUN) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end

    // ----------------------------------------
    // Shared timing chain
    // ----------------------------------------
    logic [wdt_tb_pkg::CHAIN_BITS-1:0] chain;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || pin_reset) begin
            chain <= '0;
        end else if (src_tick) begin
            chain <= chain + 1'b1;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            lcd_clk_out <= 1'b0;
            buzzer_out <= 1'b0;
        end else begin
            lcd_clk_out <= chain[wdt_tb_pkg::TAP_MIN_LOG2 - 1 + LCD_TAP_SEL];
            buzzer_out <= chain[wdt_tb_pkg::TAP_MIN_LOG2 - 1 + BUZ_TAP_SEL];
        end
    end
    // A period ends on the tick that takes the low k chain bits from all ones back to zero.
    function automatic logic period_end(input logic [wdt_tb_pkg::CHAIN_BITS-1:0] c, input int k);
        logic [wdt_tb_pkg::CHAIN_BITS-1:0] mask;
        mask = ~({wdt_tb_pkg::CHAIN_BITS{1'b1}} << k);
        period_end = (c & mask) == mask;
    endfunction : period_end

    logic [2:0] rtc_sel;
    wire logic tb_timeout = src_tick && period_end(chain, wdt_tb_pkg::TB_MIN_LOG2 + TB_DIV_SEL);
    wire logic ci_timeout = src_tick && period_end(chain, wdt_tb_pkg::RTC_MIN_LOG2 + int'(rtc_sel));

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic quick_start, tb_en, ci_en, tb_flag, ci_flag, to_flag, pd_flag;
    wire logic wr_ctl = reg_wr_in && reg_addr_in == wdt_tb_pkg::RTC_CONTROL_ADDR;
    wire logic wr_irq = reg_wr_in && reg_addr_in == wdt_tb_pkg::SECOND_IRQ_CONTROL_ADDR;
    logic wdt_overflow;
    wire logic full_reset = pin_reset || (wdt_overflow && !halted);
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || full_reset) begin
            rtc_sel <= wdt_tb_pkg::RTC_CONTROL_RESET[2:0];
            quick_start <= 1'b0;
        end else if (wr_ctl) begin
            rtc_sel <= reg_wdata_in[2:0];
            quick_start <= reg_wdata_in[wdt_tb_pkg::QUICK_START_BIT];
        end
    end
    assign crystal_quick_start_out = quick_start;
    // Hardware set wins over software clear or service acknowledge.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || full_reset) begin
            tb_en <= 1'b0;
            ci_en <= 1'b0;
            tb_flag <= 1'b0;
            ci_flag <= 1'b0;
        end else begin
            if (wr_irq) begin
                tb_en <= reg_wdata_in[wdt_tb_pkg::TB_ENABLE_BIT];
                ci_en <= reg_wdata_in[wdt_tb_pkg::CI_ENABLE_BIT];
            end
            if (tb_timeout) begin
                tb_flag <= 1'b1;
            end else if (irq_ack_tb_in) begin
                tb_flag <= 1'b0;
            end else if (wr_irq) begin
                tb_flag <= reg_wdata_in[wdt_tb_pkg::TB_FLAG_BIT];
            end
            if (ci_timeout) begin
                ci_flag <= 1'b1;
            end else if (irq_ack_ci_in) begin
                ci_flag <= 1'b0;
            end else if (wr_irq) begin
                ci_flag <= reg_wdata_in[wdt_tb_pkg::CI_FLAG_BIT];
            end
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    logic first_seen;
    wire logic wd_clr_single = wdt_enable_in && !clear_mode_dual_in && watchdog_clear_single_in;
    wire logic wd_clr_dual = wdt_enable_in && clear_mode_dual_in && first_seen && watchdog_clear_second_in;
    wire logic halt_go = halt_in && state == wdt_tb_pkg::RUN;
    wire logic wd_clear = pin_reset || wd_clr_single || wd_clr_dual || (wdt_enable_in && halt_go);
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || wd_clear || !clear_mode_dual_in || !wdt_enable_in) begin
            first_seen <= 1'b0;
        end else if (watchdog_clear_first_in) begin
            first_seen <= 1'b1;
        end
    end
    logic [wdt_tb_pkg::CHAIN_BITS-1:0] wd_cnt;
    localparam int WD_LOG2 = wdt_tb_pkg::WDT_MIN_LOG2 + WDT_DIV_SEL;
    always_comb begin
        wdt_overflow = wdt_enable_in && src_tick && (&wd_cnt[WD_LOG2-1:0]);
    end
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || wd_clear || wdt_overflow || !wdt_enable_in) begin
            wd_cnt <= '0;
        end else if (src_tick) begin
            wd_cnt <= wd_cnt + 1'b1;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            chip_reset_out <= 1'b0;
            warm_reset_out <= 1'b0;
        end else begin
            chip_reset_out <= wdt_overflow && !halted;
            warm_reset_out <= wdt_overflow && halted;
        end
    end
    // Power-up reset clears both flags; pin reset leaves them.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            to_flag <= 1'b0;
            pd_flag <= 1'b0;
        end else if (wdt_overflow) begin
            to_flag <= 1'b1;
        end else if (halt_go) begin
            pd_flag <= 1'b1;
            to_flag <= 1'b0;
        end else if (wd_clr_single) begin
            pd_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Halt and wake-up
    // ----------------------------------------
    logic tb_pre, ci_pre;
    wire logic port_wake = |(pa_prev & ~pa_s2 & porta_wake_en_in);
    wire logic tb_wake = tb_timeout && !tb_pre;
    wire logic ci_wake = ci_timeout && !ci_pre;
    wire logic irq_wake = tb_wake || ci_wake || other_irq_in;
    wire logic service = (tb_wake && tb_en) || (ci_wake && ci_en);
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state <= wdt_tb_pkg::RUN;
            wake_cnt <= '0;
            wake_irq_call <= 1'b0;
            tb_pre <= 1'b0;
            ci_pre <= 1'b0;
        end else begin
            case (state)
                wdt_tb_pkg::RUN: begin
                    if (halt_go) begin
                        state <= wdt_tb_pkg::HALTED;
                        tb_pre <= tb_flag;
                        ci_pre <= ci_flag;
                    end
                end
                wdt_tb_pkg::HALTED: begin
                    if (pin_reset || wdt_overflow || port_wake || irq_wake) begin
                        state <= wdt_tb_pkg::WAKE_DELAY;
                        wake_cnt <= 11'(wdt_tb_pkg::WAKE_DELAY_CYCLES - 1);
                        wake_irq_call <= irq_wake && service && !stack_full_in && !port_wake;
                    end
                end
                wdt_tb_pkg::WAKE_DELAY: begin
                    if (wake_cnt == '0) begin
                        state <= wdt_tb_pkg::RUN;
                    end else begin
                        wake_cnt <= wake_cnt - 11'h001;
                    end
                end
                default: state <= wdt_tb_pkg::RUN;
            endcase
        end
    end
    assign sysclk_enable_out = !halted;
    assign cpu_run_out = state == wdt_tb_pkg::RUN;

    // Interrupt call after the delay, or on a fresh enabled request when running.
    wire logic run_call = state == wdt_tb_pkg::RUN && !stack_full_in && ((tb_timeout && tb_en) || (ci_timeout && ci_en));
    wire logic delay_done = state == wdt_tb_pkg::WAKE_DELAY && wake_cnt == '0 && wake_irq_call;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            irq_call_out <= 1'b0;
            irq_vector_out <= 8'h00;
        end else begin
            irq_call_out <= run_call || delay_done;
            if (tb_flag && tb_en || tb_timeout && tb_en) begin
                irq_vector_out <= 8'h14;
            end else begin
                irq_vector_out <= 8'h18;
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || !reg_rd_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            case (reg_addr_in)
                wdt_tb_pkg::RTC_CONTROL_ADDR: reg_rdata_out <= {3'h0, quick_start, 1'b0, rtc_sel};
                wdt_tb_pkg::SECOND_IRQ_CONTROL_ADDR: reg_rdata_out <= {1'b0, ci_flag, tb_flag, 2'h0, ci_en, tb_en, 1'b0};
                wdt_tb_pkg::WDT_STATUS_ADDR: reg_rdata_out <= {5'h00, halted, pd_flag, to_flag};
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_halt_sets_pd: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        halt_go && !wdt_overflow |=> pd_flag && !to_flag) else $error("halt flags wrong");

    a_run_overflow_reset: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        wdt_overflow && !halted |=> chip_reset_out && to_flag) else $error("no chip reset");

    a_halt_overflow_warm: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        wdt_overflow && halted |=> warm_reset_out && !chip_reset_out) else $error("no warm reset");

    a_disabled_no_reset: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !wdt_enable_in |=> !chip_reset_out && !warm_reset_out) else $error("disabled watchdog acted");

    a_wake_delay_len: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        $rose(state == wdt_tb_pkg::WAKE_DELAY) |-> !cpu_run_out [*8]) else $error("wake too early");

    a_halt_stops_clock: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        halt_go |=> !sysclk_enable_out) else $error("clock not stopped");

    a_halt_clears_wdt: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        halt_go && wdt_enable_in |=> wd_cnt == '0) else $error("watchdog not cleared");

    a_tb_flag_sets: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in || full_reset)
        tb_timeout |=> tb_flag) else $error("time base flag missing");
endmodule : wdt_timebase
`default_nettype wire

/* File: dv/wdt_timebase_bench.sv */
// Self-checking bench for the watchdog, timing chain, time base, interval timer and halt block.
// Assumes rtl/wdt_tb_pkg.sv and rtl/wdt_timebase.sv are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module wdt_timebase_bench;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic qs;
    } reg_row_t;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wdt_en = 1'b1;
    logic dual = 1'b0;
    logic [7:0] wake_en = 8'h00;
    logic rc_osc = 1'b0;
    logic rc_ph = 1'b0;
    logic rc_run = 1'b0;
    logic [7:0] porta = 8'hFF;
    logic [5:0] pulses = 6'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] src = wdt_tb_pkg::SRC_RC;
    logic rst_pin_n = 1'b1;
    logic stack_full = 1'b0;
    logic other_irq = 1'b0;
    logic [7:0] rdata;
    logic [7:0] vec;
    logic [7:0] vec_q = 8'h00;
    logic chip_rst, warm_rst, sysclk_en, cpu_run, irq_call, lcd, buzz, qs;
    logic lcd_q = 1'b0;
    logic buzz_q = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int n_chip = 0;
    int n_warm = 0;
    int n_lcd = 0;
    int n_buzz = 0;
    int n_call = 0;
    int at, c0, w0, b0, b1;
    logic [7:0] d;
    reg_row_t rows [5] = '{'{8'h09, 8'h17, 8'h17, 1'b1}, '{8'h09, 8'h03, 8'h03, 1'b0},
        '{8'h1E, 8'h06, 8'h06, 1'b0}, '{8'h40, 8'hFF, 8'h00, 1'b0}, '{8'h55, 8'hFF, 8'h00, 1'b0}};

    wdt_timebase #(.WDT_DIV_SEL(0), .TB_DIV_SEL(0), .LCD_TAP_SEL(0), .BUZ_TAP_SEL(1)) dut_u (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .wdt_enable_in(wdt_en),
        .wdt_source_in(src), .clear_mode_dual_in(dual), .porta_wake_en_in(wake_en),
        .rc_osc_in(rc_osc), .rtc_osc_in(rc_osc), .external_reset_pin_n_in(rst_pin_n), .porta_in(porta),
        .watchdog_clear_single_in(pulses[0]), .watchdog_clear_first_in(pulses[1]),
        .watchdog_clear_second_in(pulses[2]), .halt_in(pulses[3]), .other_irq_in(other_irq),
        .stack_full_in(stack_full), .irq_ack_tb_in(pulses[4]), .irq_ack_ci_in(pulses[5]),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .chip_reset_out(chip_rst), .warm_reset_out(warm_rst),
        .sysclk_enable_out(sysclk_en), .cpu_run_out(cpu_run), .irq_call_out(irq_call),
        .irq_vector_out(vec), .lcd_clk_out(lcd), .buzzer_out(buzz), .crystal_quick_start_out(qs));

    // ----------------------------------------
    // Clock, oscillator pin and pulse monitors
    // ----------------------------------------
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // The oscillator pin has a period of four system cycles and rests low when stopped.
    always @(posedge clk_sys_in) begin
        rc_ph <= ~rc_ph;
        if (rc_ph) rc_osc <= rc_run & ~rc_osc;
        lcd_q <= lcd;
        buzz_q <= buzz;
        if (chip_rst === 1'b1) n_chip <= n_chip + 1;
        if (warm_rst === 1'b1) n_warm <= n_warm + 1;
        if (irq_call === 1'b1) n_call <= n_call + 1;
        if (irq_call === 1'b1) vec_q <= vec;
        if (lcd === 1'b1 && lcd_q === 1'b0) n_lcd <= n_lcd + 1;
        if (buzz === 1'b1 && buzz_q === 1'b0) n_buzz <= n_buzz + 1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : chk_rng

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        @(negedge clk_sys_in);
        v = rdata;
    endtask : reg_rd

    task automatic pulse(input logic [5:0] m);
        @(posedge clk_sys_in);
        pulses <= m;
        @(posedge clk_sys_in);
        pulses <= 6'h00;
    endtask : pulse

    task automatic reset_dut();
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        rc_run <= 1'b0;
        wdt_en <= 1'b1;
        dual <= 1'b0;
        wake_en <= 8'h00;
        porta <= 8'hFF;
        src <= wdt_tb_pkg::SRC_RC;
        rst_pin_n <= 1'b1;
        stack_full <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        c0 = n_chip;
        w0 = n_warm;
    endtask : reset_dut

    // Runs maxc cycles with m1 then m2 pulsed at the end of each period; at is the first reset seen.
    task automatic run_wd(input int maxc, input int per, input logic [5:0] m1, input logic [5:0] m2,
                          output int at);
        int base;
        base = n_chip + n_warm;
        at = maxc;
        for (int i = 0; i < maxc; i++) begin
            @(posedge clk_sys_in);
            pulses <= (i % per == per - 2) ? m1 : ((i % per == per - 1) ? m2 : 6'h00);
            if (at == maxc && n_chip + n_warm != base) at = i;
        end
        @(posedge clk_sys_in);
        pulses <= 6'h00;
    endtask : run_wd

    task automatic final_report();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (95000) @(posedge clk_sys_in);
        n_fail++;
        final_report();
    end

    // ----------------------------------------
    // Register rows, then hand-written cases
    // ----------------------------------------
    initial begin
        reset_dut();
        reg_rd(wdt_tb_pkg::RTC_CONTROL_ADDR, d);
        chk8("rtc_control reset", wdt_tb_pkg::RTC_CONTROL_RESET, d);
        reg_rd(wdt_tb_pkg::WDT_STATUS_ADDR, d);
        chk8("status reset", 8'h00, d);
        foreach (rows[k]) begin
            reg_wr(rows[k].addr, rows[k].wdata);
            reg_rd(rows[k].addr, d);
            chk8("register row", rows[k].rdata, d);
            chk8("quick start", {7'h00, rows[k].qs}, {7'h00, qs});
        end
        // Dual mode ignores single clears, so the count overflows at 2^12 oscillator ticks.
        reset_dut();
        dual <= 1'b1;
        rc_run <= 1'b1;
        run_wd(17000, 4000, 6'h00, 6'h01, at);
        chk_rng("overflow cycle", 16330, 16450, at);
        chk_rng("chip resets", 1, 1, n_chip - c0);
        chk_rng("warm resets", 0, 0, n_warm - w0);
        reg_rd(wdt_tb_pkg::WDT_STATUS_ADDR, d);
        chk8("status after overflow", 8'h01, d);
        reset_dut();
        dual <= 1'b1;
        rc_run <= 1'b1;
        run_wd(24000, 8000, 6'h02, 6'h04, at);
        chk_rng("resets with paired clears", 0, 0, n_chip + n_warm - c0 - w0);
        reset_dut();
        wdt_en <= 1'b0;
        src <= wdt_tb_pkg::SRC_RTC;
        rc_run <= 1'b1;
        reg_wr(wdt_tb_pkg::RTC_CONTROL_ADDR, 8'h00);
        run_wd(17000, 4000, 6'h01, 6'h01, at);
        chk_rng("resets while disabled", 0, 0, n_chip + n_warm - c0 - w0);
        reg_rd(wdt_tb_pkg::SECOND_IRQ_CONTROL_ADDR, d);
        chk8("request flags", 8'h60, d);
        pulse(6'h30);
        reg_rd(wdt_tb_pkg::SECOND_IRQ_CONTROL_ADDR, d);
        chk8("flags after service", 8'h00, d);
        b0 = n_lcd;
        b1 = n_buzz;
        repeat (1600) @(posedge clk_sys_in);
        chk_rng("lcd edges", 98, 102, n_lcd - b0);
        chk_rng("buzzer edges", 48, 52, n_buzz - b1);
        // Halt with a port wake, where only the enabled pin may wake the device.
        reset_dut();
        wake_en <= 8'h01;
        pulse(6'h08);
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk8("halted clocks", 8'h00, {6'h00, sysclk_en, cpu_run});
        reg_rd(wdt_tb_pkg::WDT_STATUS_ADDR, d);
        chk8("status halted", 8'h06, d);
        @(posedge clk_sys_in);
        porta <= 8'hFD;
        repeat (20) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk8("disabled pin", 8'h00, {6'h00, sysclk_en, cpu_run});
        @(posedge clk_sys_in);
        porta <= 8'hFC;
        repeat (10) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk8("wake delay", 8'h02, {6'h00, sysclk_en, cpu_run});
        repeat (1000) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk8("still delayed", 8'h00, {7'h00, cpu_run});
        repeat (40) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk8("resumed", 8'h01, {7'h00, cpu_run});
        reg_rd(wdt_tb_pkg::WDT_STATUS_ADDR, d);
        chk8("status after wake", 8'h02, d);
        pulse(6'h01);
        reg_rd(wdt_tb_pkg::WDT_STATUS_ADDR, d);
        chk8("status after clear", 8'h00, d);
        // An overflow while halted gives a warm reset only, timed from the halt.
        reset_dut();
        rc_run <= 1'b1;
        pulse(6'h08);
        run_wd(17000, 4000, 6'h00, 6'h00, at);
        chk_rng("halted overflow cycle", 16330, 16450, at);
        chk_rng("warm resets", 1, 1, n_warm - w0);
        chk_rng("chip resets halted", 0, 0, n_chip - c0);
        repeat (600) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk8("run after warm reset", 8'h01, {7'h00, cpu_run});
        reg_rd(wdt_tb_pkg::WDT_STATUS_ADDR, d);
        chk8("status warm reset", 8'h03, d);
        // Instruction clock: interval calls, a full stack, then pin reset and interrupt wakes.
        reset_dut();
        src <= wdt_tb_pkg::SRC_INSTR;
        reg_wr(wdt_tb_pkg::RTC_CONTROL_ADDR, 8'h00);
        reg_wr(wdt_tb_pkg::SECOND_IRQ_CONTROL_ADDR, 8'h04);
        b0 = n_call;
        repeat (2500) @(posedge clk_sys_in);
        chk_rng("interval calls", 2, 2, n_call - b0);
        chk8("call vector", 8'h18, vec_q);
        stack_full <= 1'b1;
        repeat (1100) @(posedge clk_sys_in);
        chk_rng("calls with full stack", 2, 2, n_call - b0);
        pulse(6'h08);
        rst_pin_n <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        rst_pin_n <= 1'b1;
        reg_rd(wdt_tb_pkg::RTC_CONTROL_ADDR, d);
        chk8("control after pin reset", wdt_tb_pkg::RTC_CONTROL_RESET, d);
        chk8("pin wake", 8'h02, {6'h00, sysclk_en, cpu_run});
        repeat (1030) @(posedge clk_sys_in);
        pulse(6'h08);
        other_irq <= 1'b1;
        @(posedge clk_sys_in);
        other_irq <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk8("interrupt wake", 8'h02, {6'h00, sysclk_en, cpu_run});
        final_report();
    end
endmodule : wdt_timebase_bench
`default_nettype wire
